// *** src/radio_mode_symbol_config.sv ***
// APB configuration bank for radio mode, trim and symbol coding settings
//
// Notes on behaviour
// - Seven-bit phase trim, top bit reads zero.
// - Seven-bit amplitude trim, top bit reads zero.
// - Wake enable bit turns smart wake on.
// - Calibrate filter on off-to-idle when enabled.
// - Wake signal-strength qualify follows its bit.
// - Auto receive after transmit when bit set.
// - Auto transmit after valid receive when set.
// - Turnarounds happen only in packet mode.
// - Custom lock time selected by enable bit.
// - LNA output high in receive when enabled.
// - PA output high in transmit when enabled.
// - Preamble tolerance selects twelve-pair match errors.
// - Block coding bit enables 8b/10b both ways.
// - Whitening bit enables whiten and dewhiten.
// - Symbol length zero eight bits, one ten.
// - Lock after preamble, sync only if disabled.
//
// Our own choice: the APB slave port.

`timescale 1ns/10ps
`default_nettype none
`include "radio_cfg_params.svh"

// Five byte-wide registers, one per bus word. Each
// transfer has one wait-free access cycle; fields
// feed the radio controller and amplifier pins.
module radio_mode_symbol_config #(
  parameter int          ADDR_W        = 12,       // APB address width
  parameter logic [15:0] DEFAULT_LOCK  = 16'h0000  // Built-in lock time
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // Radio controller status, same clock domain
  input  wire radio_cfg_pkg::radio_state_t radio_state,
  input  wire logic                      packet_mode,
  input  wire logic                      tx_packet_done,
  input  wire logic                      rx_packet_valid,
  input  wire logic [15:0]               custom_lock_time,
  input  wire logic [1:0]                frequency_control_lock_select,
  // Radio controller requests
  output logic                           auto_receive_request,
  output logic                           auto_transmit_request,
  output logic                           filter_cal_start,
  output logic [15:0]                    synth_lock_time,
  // External amplifier control pins
  output logic                           lna_control_output,
  output logic                           pa_control_output,
  // Trim and mode settings
  output logic [6:0]                     iq_phase_adjust,
  output logic [6:0]                     iq_amplitude_adjust,
  output logic                           low_power_wake_enable,
  output logic                           wake_signal_strength_qualify,
  // Preamble detection settings
  output logic                           preamble_detect_enable,
  output logic [3:0]                     preamble_min_good_pairs,
  output logic                           lock_on_preamble,
  output logic                           lock_on_sync,
  // Symbol coding settings
  output logic                           manchester_coding_enable,
  output logic                           programmable_crc_select,
  output logic                           block_coding_enable,
  output logic                           whitening_enable,
  output logic [2:0]                     symbol_length_sel
);

  // Fields clear on presetn and feed the radio side
  // directly; a write shows one edge after access
  // Stored register fields; reserved bits are not stored
  logic [6:0]  phase_q,  phase_d;     // Phase trim value
  logic [6:0]  ampl_q,   ampl_d;      // Amplitude trim value
  logic [7:0]  behav_q,  behav_d;     // Behaviour control bits
  logic [3:0]  ptol_q,   ptol_d;      // Preamble tolerance
  logic [6:0]  coding_q, coding_d;    // Line coding bits

  // Bus answer registers
  logic [31:0] prdata_q,  prdata_d;   // Read data for access phase
  logic        pready_q,  pready_d;   // Ready for access phase
  logic        pslverr_q, pslverr_d;  // Error for unmapped address

  // Radio side registers
  radio_cfg_pkg::radio_state_t prev_state_q, prev_state_d; // Last state
  logic        auto_rx_q,   auto_rx_d;    // Receive request pulse
  logic        auto_tx_q,   auto_tx_d;    // Transmit request pulse
  logic        cal_q,       cal_d;        // Calibration start pulse
  logic [15:0] lock_q,      lock_d;       // Chosen lock time
  logic        lna_q,       lna_d;        // LNA pin level
  logic        pa_q,        pa_d;         // PA pin level
  logic        pre_en_q,    pre_en_d;     // Preamble detect enable
  logic        lock_pre_q,  lock_pre_d;   // Lock on preamble
  logic        lock_sync_q, lock_sync_d;  // Lock on sync word

  // Address decode helpers
  logic [9:0]  word_idx;                  // Word index of paddr
  logic        aligned;                   // Byte offset is zero
  logic        hit;                       // Address maps a register
  logic        setup;                     // Setup phase of a transfer
  logic        wr_go;                     // Write takes effect now
  logic [7:0]  rd_byte;                   // Selected register value

  // Only byte address bits [11:0] are decoded; all
  // five registers fit the default bus width
  assign word_idx = paddr[11:2];
  assign aligned  = (paddr[1:0] == 2'h0);
  assign setup    = psel & ~penable;
  // Write lands only at the completing edge of the access phase
  assign wr_go    = psel & penable & pready_q & pwrite & hit & pstrb[0];

  // Reserved bits are not stored but rebuilt as zero,
  // so software never reads back a stray one
  // Address decode and read mux; reserved bits read as zero
  always_comb begin
    rd_byte = 8'h00;
    hit     = 1'b0;
    if (aligned) begin
      unique case (word_idx)
        `IDX_IQ_PHASE_TRIM: begin
          hit     = 1'b1;
          rd_byte = {1'b0, phase_q};
        end
        `IDX_IQ_AMPLITUDE_TRIM: begin
          hit     = 1'b1;
          rd_byte = {1'b0, ampl_q};
        end
        `IDX_RADIO_BEHAV_CTRL: begin
          hit     = 1'b1;
          rd_byte = behav_q;
        end
        `IDX_PREAMBLE_TOL: begin
          hit     = 1'b1;
          rd_byte = {4'h0, ptol_q};
        end
        `IDX_LINE_CODING_CFG: begin
          hit     = 1'b1;
          rd_byte = {1'b0, coding_q};
        end
        default: begin
          // Unmapped word: read zero, answer with an error
          hit     = 1'b0;
          rd_byte = 8'h00;
        end
      endcase
    end
  end

  // Fields change only at the edge that ends a full
  // transfer; refused addresses leave them alone
  // Next values of the register fields
  always_comb begin
    phase_d  = phase_q;
    ampl_d   = ampl_q;
    behav_d  = behav_q;
    ptol_d   = ptol_q;
    coding_d = coding_q;
    if (wr_go) begin
      unique case (word_idx)
        `IDX_IQ_PHASE_TRIM: begin
          // Reserved top bit is dropped
          phase_d = pwdata[`TRIM_MSB:0];
        end
        `IDX_IQ_AMPLITUDE_TRIM: begin
          ampl_d = pwdata[`TRIM_MSB:0];
        end
        `IDX_RADIO_BEHAV_CTRL: begin
          behav_d = pwdata[7:0];
        end
        `IDX_PREAMBLE_TOL: begin
          ptol_d = pwdata[`PRE_TOL_MSB:0];
        end
        `IDX_LINE_CODING_CFG: begin
          coding_d = pwdata[6:0];
        end
        default: begin
          // Nothing stored for other words
          phase_d = phase_q;
        end
      endcase
    end
  end

  // Reset leaves every option, turnaround and
  // amplifier output off until software sets it
  // Register fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q  <= `RST_IQ_PHASE_TRIM;
      ampl_q   <= `RST_IQ_AMPLITUDE_TRIM;
      behav_q  <= `RST_RADIO_BEHAV_CTRL;
      ptol_q   <= `RST_PREAMBLE_TOL;
      coding_q <= `RST_LINE_CODING_CFG;
    end else begin
      phase_q  <= phase_d;
      ampl_q   <= ampl_d;
      behav_q  <= behav_d;
      ptol_q   <= ptol_d;
      coding_q <= coding_d;
    end
  end

  // Decode happens in setup and is registered, so the
  // answer comes from flops; no transfer ends in setup
  // Bus answer: captured in setup, so access phase always takes one cycle
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup & ~hit;
    prdata_d  = prdata_q;
    if (setup) begin
      prdata_d = (hit && !pwrite) ? {24'h000000, rd_byte} : `RDATA_ZERO;
    end
  end

  // Read data keeps its last word after the access;
  // it means nothing once ready has fallen
  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= `RDATA_ZERO;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Radio status shares this clock: no synchroniser.
  // Each request or pin lags its cause by one edge.
  // Radio side decisions, all registered so pins come from flip-flops
  always_comb begin
    prev_state_d = radio_state;
    // Status pulses last one cycle, so each one
    // yields exactly one request pulse
    // Turnarounds are gated by packet mode; stream modes never turn round
    auto_rx_d = behav_q[`BIT_TX_TO_RX] & packet_mode
              & tx_packet_done;
    auto_tx_d = behav_q[`BIT_RX_TO_TX] & packet_mode
              & rx_packet_valid;
    // One pulse per power-up edge from off to idle
    cal_d = behav_q[`BIT_FILTER_CAL_EN]
          & (prev_state_q == radio_cfg_pkg::powered_off_state)
          & (radio_state == radio_cfg_pkg::powered_idle_state);
    // Custom time is a level; write both bytes before
    // setting the enable, or a mixed value is used
    lock_d = behav_q[`BIT_CUSTOM_LOCK] ? custom_lock_time
                                       : DEFAULT_LOCK;
    // Disabled or sleeping pins sit low; the pin has no tri-state here
    lna_d = behav_q[`BIT_LNA_OUT_EN]
          & (radio_state == radio_cfg_pkg::receive_state);
    pa_d  = behav_q[`BIT_PA_OUT_EN]
          & (radio_state == radio_cfg_pkg::transmit_state);
    // Codes 1 to 7 are poor but legal, so they enable
    // detection; 13 to 15 are reserved
    // Detection runs for 1 to 12; zero and reserved codes switch it off
    pre_en_d = (ptol_q != `PRE_TOL_OFF)
             & (ptol_q <= `PRE_TOL_MAX);
    // Sync lock only for tolerance code zero; reserved codes 13 to 15 give neither lock
    lock_pre_d  = (frequency_control_lock_select == `LOCK_MODE_LOCK)
                & pre_en_d;
    lock_sync_d = (frequency_control_lock_select == `LOCK_MODE_LOCK)
                & (ptol_q == `PRE_TOL_OFF);
  end

  // Previous state starts powered off, so the first
  // move to idle after reset can start a calibration
  // Radio side registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_state_q <= radio_cfg_pkg::powered_off_state;
      auto_rx_q    <= 1'b0;
      auto_tx_q    <= 1'b0;
      cal_q        <= 1'b0;
      lock_q       <= 16'h0000;
      lna_q        <= 1'b0;
      pa_q         <= 1'b0;
      pre_en_q     <= 1'b0;
      lock_pre_q   <= 1'b0;
      lock_sync_q  <= 1'b0;
    end else begin
      prev_state_q <= prev_state_d;
      auto_rx_q    <= auto_rx_d;
      auto_tx_q    <= auto_tx_d;
      cal_q        <= cal_d;
      lock_q       <= lock_d;
      lna_q        <= lna_d;
      pa_q         <= pa_d;
      pre_en_q     <= pre_en_d;
      lock_pre_q   <= lock_pre_d;
      lock_sync_q  <= lock_sync_d;
    end
  end

  // Pins below are plain wires from the flops above
  // Bus outputs
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Requests are pulses; the radio controller makes
  // the actual state change and times it
  // Radio requests and pins
  assign auto_receive_request  = auto_rx_q;
  assign auto_transmit_request = auto_tx_q;
  assign filter_cal_start      = cal_q;
  assign synth_lock_time       = lock_q;
  assign lna_control_output    = lna_q;
  assign pa_control_output     = pa_q;

  // Settings are levels; what a reserved symbol length
  // code means is left to the radio controller
  // Settings from the stored fields; detect and lock flags from radio side flops
  assign iq_phase_adjust              = phase_q;
  assign iq_amplitude_adjust          = ampl_q;
  assign low_power_wake_enable        = behav_q[`BIT_WAKE_EN];
  assign wake_signal_strength_qualify = behav_q[`BIT_WAKE_RSSI_QUAL];
  // Qualify is only meaningful while smart wake runs
  assign preamble_detect_enable       = pre_en_q;
  // Required good pairs out of twelve; 12 - value errors allowed
  assign preamble_min_good_pairs      = ptol_q;
  assign lock_on_preamble             = lock_pre_q;
  assign lock_on_sync                 = lock_sync_q;
  assign manchester_coding_enable     = coding_q[`BIT_MANCHESTER];
  assign programmable_crc_select      = coding_q[`BIT_PROG_CRC];
  assign block_coding_enable          = coding_q[`BIT_BLOCK_CODING];
  assign whitening_enable             = coding_q[`BIT_WHITENING];
  // Reserved codes 2..7 are stored and passed on unchanged
  assign symbol_length_sel            = coding_q[`SYM_LEN_MSB:0];

endmodule // radio_mode_symbol_config

`default_nettype wire

// *** src/radio_cfg_params.svh ***
// Offsets, field positions, reset values and constants of the config bank
`ifndef RADIO_CFG_PARAMS_SVH
`define RADIO_CFG_PARAMS_SVH

// Register indices as printed; byte address is four times the index
`define IDX_IQ_PHASE_TRIM      10'h118
`define IDX_IQ_AMPLITUDE_TRIM  10'h119
`define IDX_RADIO_BEHAV_CTRL   10'h11a
`define IDX_PREAMBLE_TOL       10'h11b
`define IDX_LINE_CODING_CFG    10'h11c

// Reset values of the five registers
`define RST_IQ_PHASE_TRIM      7'h00
`define RST_IQ_AMPLITUDE_TRIM  7'h00
`define RST_RADIO_BEHAV_CTRL   8'h00
`define RST_PREAMBLE_TOL       4'h0
`define RST_LINE_CODING_CFG    7'h00

// Trim field
`define TRIM_MSB               6

// Behaviour control bits
`define BIT_WAKE_EN            7
`define BIT_FILTER_CAL_EN      6
`define BIT_WAKE_RSSI_QUAL     5
`define BIT_TX_TO_RX           4
`define BIT_RX_TO_TX           3
`define BIT_CUSTOM_LOCK        2
`define BIT_LNA_OUT_EN         1
`define BIT_PA_OUT_EN          0

// Preamble tolerance field
`define PRE_TOL_MSB            3
`define PRE_TOL_OFF            4'h0
`define PRE_TOL_MAX            4'hc
`define PRE_TOL_LEAST_ADVISED  4'h8

// Line coding bits
`define BIT_MANCHESTER         6
`define BIT_PROG_CRC           5
`define BIT_BLOCK_CODING       4
`define BIT_WHITENING          3
`define SYM_LEN_MSB            2

// Frequency control lock mode code that asks for lock
`define LOCK_MODE_LOCK         2'h3

// Read value of reserved or unmapped data
`define RDATA_ZERO             32'h0000_0000

`endif

// *** src/radio_cfg_pkg.sv ***
// Types shared by the radio mode and symbol configuration bank
`default_nettype none
package radio_cfg_pkg;

  // Radio operating state reported by the radio controller
  typedef enum logic [2:0] {
    powered_off_state,
    powered_idle_state,
    receive_state,
    transmit_state,
    sleep_state
  } radio_state_t;

endpackage : radio_cfg_pkg

`default_nettype wire

// *** tb/apb_host_model.sv ***
// APB host model that configures the radio settings bank
`timescale 1ns/10ps
`default_nettype none

module apb_host_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; no latency is assumed, pready alone ends the access
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is seen high at an edge
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data inverted so a stale word is never trusted
    pwdata  <= ~wd;
  endtask
endmodule // apb_host_model
`default_nettype wire

// *** tb/radio_mode_symbol_config_checker.sv ***
// Concurrent checks on the ports of the radio settings bank
`timescale 1ns/10ps
`default_nettype none

module radio_cfg_checker (
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // Bus and radio signals watched
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic [31:0]                 prdata,
  input  wire logic                        pready,
  input  wire logic                        pslverr,
  input  wire radio_cfg_pkg::radio_state_t radio_state,
  input  wire logic                        packet_mode,
  input  wire logic                        tx_packet_done,
  input  wire logic                        rx_packet_valid,
  input  wire logic                        auto_receive_request,
  input  wire logic                        auto_transmit_request,
  input  wire logic                        lna_control_output,
  input  wire logic                        pa_control_output,
  input  wire logic                        preamble_detect_enable,
  input  wire logic [3:0]                  preamble_min_good_pairs,
  input  wire logic                        lock_on_sync
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Setup phase of a transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  // Tolerance field unchanged over the last edge
  sequence tol_steady_s;
    $stable(preamble_min_good_pairs);
  endsequence

  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no access answer after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_error_reads_zero: assert property (pready && pslverr |-> prdata == 0)
    else $error("refused read returned data");
  a_rx_turn_cause: assert property (auto_receive_request |->
    $past(tx_packet_done && packet_mode))
    else $error("auto receive without packet mode transmit end");
  a_tx_turn_cause: assert property (auto_transmit_request |->
    $past(rx_packet_valid && packet_mode))
    else $error("auto transmit without packet mode receive");
  a_lna_in_rx: assert property (lna_control_output |->
    $past(radio_state) == radio_cfg_pkg::receive_state)
    else $error("lna output high outside receive");
  a_pa_in_tx: assert property (pa_control_output |->
    $past(radio_state) == radio_cfg_pkg::transmit_state)
    else $error("pa output high outside transmit");
  a_detect_range: assert property (preamble_detect_enable ##0
    tol_steady_s |-> preamble_min_good_pairs inside {[1:12]})
    else $error("preamble detection with disabled tolerance");
  a_sync_lock_off: assert property (lock_on_sync ##0 tol_steady_s
    |-> preamble_min_good_pairs == 0)
    else $error("sync lock while preamble detection on");
endmodule // radio_cfg_checker

bind radio_mode_symbol_config radio_cfg_checker radio_cfg_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .radio_state(radio_state), .packet_mode(packet_mode),
  .tx_packet_done(tx_packet_done), .rx_packet_valid(rx_packet_valid),
  .auto_receive_request(auto_receive_request),
  .auto_transmit_request(auto_transmit_request),
  .lna_control_output(lna_control_output),
  .pa_control_output(pa_control_output),
  .preamble_detect_enable(preamble_detect_enable),
  .preamble_min_good_pairs(preamble_min_good_pairs),
  .lock_on_sync(lock_on_sync));
`default_nettype wire

// *** tb/tb_radio_mode_symbol_config.sv ***
// Self-checking bench for the radio settings bank
`timescale 1ns/10ps
`default_nettype none
`include "radio_cfg_params.svh"

module tb_radio_mode_symbol_config;
  // Bus and radio stimulus
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  radio_cfg_pkg::radio_state_t radio_state;
  logic pm, txd, rxv, arr, atr, fcs, lna, pa, lock_pre, lock_syn;
  logic [15:0] clt, slt;
  logic [1:0] lsel;
  logic [6:0] iph, iam;
  logic wake, qual, det, man, crc, blk, wht;
  logic [3:0] mgp;
  logic [2:0] sym;
  int fails = 0, checks_done = 0, n_rx = 0, n_tx = 0, n_cal = 0;
  // Byte addresses are four times the printed index
  localparam logic [11:0] A_PH = {`IDX_IQ_PHASE_TRIM, 2'b00};
  localparam logic [11:0] A_AM = {`IDX_IQ_AMPLITUDE_TRIM, 2'b00};
  localparam logic [11:0] A_CT = {`IDX_RADIO_BEHAV_CTRL, 2'b00};
  localparam logic [11:0] A_PR = {`IDX_PREAMBLE_TOL, 2'b00};
  localparam logic [11:0] A_CD = {`IDX_LINE_CODING_CFG, 2'b00};

  radio_mode_symbol_config radio_mode_symbol_config_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .radio_state(radio_state), .packet_mode(pm), .tx_packet_done(txd),
    .rx_packet_valid(rxv), .custom_lock_time(clt),
    .frequency_control_lock_select(lsel), .auto_receive_request(arr),
    .auto_transmit_request(atr), .filter_cal_start(fcs),
    .synth_lock_time(slt), .lna_control_output(lna),
    .pa_control_output(pa), .iq_phase_adjust(iph),
    .iq_amplitude_adjust(iam), .low_power_wake_enable(wake),
    .wake_signal_strength_qualify(qual), .preamble_detect_enable(det),
    .preamble_min_good_pairs(mgp), .lock_on_preamble(lock_pre),
    .lock_on_sync(lock_syn), .manchester_coding_enable(man),
    .programmable_crc_select(crc), .block_coding_enable(blk),
    .whitening_enable(wht), .symbol_length_sel(sym));
  apb_host_model apb_host_model_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Clock of 40 ns
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Pulse counters; counting avoids guessing the exact edge of a pulse
  always @(posedge pclk) begin
    n_rx <= n_rx + int'(arr === 1'b1);
    n_tx <= n_tx + int'(atr === 1'b1);
    n_cal <= n_cal + int'(fcs === 1'b1);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_host_model_inst.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x,
                        input logic xe);
    logic [31:0] r;
    logic e;
    apb_host_model_inst.xfer(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // Let registered outputs settle, then look between edges
  task automatic settle;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Reserved top bit of both trims reads zero; fields drive the outputs
  task automatic t_trim;
    wr(A_PH, 32'hffff_ffff);
    rd_chk(A_PH, 32'h7f, 1'b0);
    wr(A_AM, 32'h0000_00d5);
    rd_chk(A_AM, 32'h55, 1'b0);
    chk({iph, iam}, 32'h3fd5);
    $display("test trim done");
  endtask
  // Walk one bit through the control word
  task automatic t_ctrl;
    for (int b = 0; b < 8; b++) begin
      wr(A_CT, 32'h1 << b);
      rd_chk(A_CT, 32'h1 << b, 1'b0);
      settle();
      chk({wake, qual}, {b == 7, b == 5});
      chk(slt, (b == 2) ? clt : 16'h0000);
    end
    $display("test ctrl done");
  endtask
  // Turnaround table: control word, packet mode, expected pulses
  task automatic t_turn;
    logic [7:0] c [4] = '{8'h18, 8'h10, 8'h08, 8'h18};
    logic m [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    int r0, t0;
    for (int i = 0; i < 4; i++) begin
      wr(A_CT, {24'h0, c[i]});
      r0 = n_rx;
      t0 = n_tx;
      @(posedge pclk);
      pm <= m[i];
      txd <= 1'b1;
      @(posedge pclk);
      txd <= 1'b0;
      rxv <= 1'b1;
      @(posedge pclk);
      rxv <= 1'b0;
      settle();
      chk(n_rx - r0, c[i][4] & m[i]);
      chk(n_tx - t0, c[i][3] & m[i]);
    end
    $display("test turnaround done");
  endtask
  // Amplifier outputs across states, then with enables off
  task automatic t_amp;
    radio_cfg_pkg::radio_state_t s [5] = '{radio_cfg_pkg::receive_state,
      radio_cfg_pkg::transmit_state, radio_cfg_pkg::powered_idle_state,
      radio_cfg_pkg::sleep_state, radio_cfg_pkg::receive_state};
    for (int i = 0; i < 5; i++) begin
      wr(A_CT, (i == 4) ? 32'h0 : 32'h3);
      radio_state <= s[i];
      settle();
      chk({lna, pa}, {i == 0, i == 1});
    end
    $display("test amplifier done");
  endtask
  // Off to idle calibrates only with the enable set
  task automatic t_cal;
    int n0;
    for (int en = 1; en >= 0; en--) begin
      wr(A_CT, en ? 32'h40 : 32'h0);
      radio_state <= radio_cfg_pkg::powered_off_state;
      settle();
      @(posedge pclk);
      n0 = n_cal;
      radio_state <= radio_cfg_pkg::powered_idle_state;
      settle();
      chk(n_cal - n0, en);
    end
    $display("test calibration done");
  endtask
  // Tolerance codes at the edges of each range, lock mode asking lock
  task automatic t_pre;
    logic [3:0] t [5] = '{4'h0, 4'h1, 4'h8, 4'hc, 4'hd};
    logic d;
    @(posedge pclk);
    lsel <= 2'h3;
    for (int i = 0; i < 5; i++) begin
      d = t[i] inside {[1:12]};
      wr(A_PR, {28'h000000f, t[i]});
      rd_chk(A_PR, {28'h0, t[i]}, 1'b0);
      settle();
      chk({det, mgp, lock_pre, lock_syn}, {d, t[i], d, t[i] == 0});
    end
    $display("test preamble done");
  endtask
  // Coding word patterns; reserved bit 7 reads zero
  task automatic t_code;
    logic [7:0] v [3] = '{8'hff, 8'h2a, 8'h51};
    for (int i = 0; i < 3; i++) begin
      wr(A_CD, {24'h0, v[i]});
      rd_chk(A_CD, {25'h0, v[i][6:0]}, 1'b0);
      chk({man, crc, blk, wht, sym}, v[i][6:0]);
    end
    $display("test coding done");
  endtask
  // Unmapped and misaligned accesses are refused
  task automatic t_err;
    wr(12'h474, 32'h7f);
    rd_chk(12'h474, 32'h0, 1'b1);
    rd_chk(A_PH + 12'h1, 32'h0, 1'b1);
    rd_chk(A_PH, 32'h7f, 1'b0);
    $display("test refusal done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after a 20 cycle reset
  initial begin
    {presetn, pm, txd, rxv} = '0;
    radio_state = radio_cfg_pkg::powered_off_state;
    clt = 16'h5a3c;
    lsel = 2'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_CT, 32'h0, 1'b0);
    t_trim();
    t_ctrl();
    t_turn();
    t_amp();
    t_cal();
    t_pre();
    t_code();
    t_err();
    close_out();
  end
  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #400000;
    fails++;
    close_out();
  end
endmodule // tb_radio_mode_symbol_config
`default_nettype wire
